/* include/lpw_defines.svh */
/*
 * Constants of the low-power wake-up gating block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes it is included by bare name and compiled before the design.
 */
`ifndef LPW_DEFINES_SVH
`define LPW_DEFINES_SVH

// ============================================================
// Register byte offsets.
`define LPW_OFS_MODE 8'h00
`define LPW_OFS_PINFN 8'h04
`define LPW_OFS_STPINS 8'h08
`define LPW_OFS_STPER 8'h0c
`define LPW_OFS_BODCTL 8'h10
`define LPW_OFS_SLPPWR 8'h14
`define LPW_OFS_WDMODE 8'h18
`define LPW_OFS_DPDCTL 8'h1c
`define LPW_OFS_WKTCTL 8'h20
`define LPW_OFS_WKTCNT 8'h24
`define LPW_OFS_COREEN 8'h28
`define LPW_OFS_STATUS 8'h2c
`define LPW_OFS_MASK 8'h30
`define LPW_OFS_WSRC 8'h34

// ============================================================
// Field positions.
`define LPW_CORE_BOD 8
`define LPW_CORE_WDT 9
`define LPW_CORE_WKT 10
`define LPW_CORE_SER_LO 11
`define LPW_CORE_TOUCH 14
`define LPW_CORE_GEN 15
`define LPW_SP_BOD 0
`define LPW_SP_WDT 1
`define LPW_SP_WKT 2
`define LPW_SP_SER 3
`define LPW_SP_TOUCH 4
`define LPW_BOD_IRQEN 0
`define LPW_BOD_RSTEN 1
`define LPW_SLP_BODPWR 0
`define LPW_SLP_WDOPWR 1
`define LPW_WD_EN 0
`define LPW_WD_RSTEN 1
`define LPW_WD_IRQEN 2
`define LPW_DPD_WKPIN 0
`define LPW_DPD_RSTPIN 1
`define LPW_DPD_LPOSC 2
`define LPW_DPD_LPKEEP 3
`define LPW_ST_WAKE 0
`define LPW_ST_WKT 1

// ============================================================
// Reset values and timing.
`define LPW_RST_ZERO 32'h0000_0000
`define LPW_LPOSC_DIV 16'h0009

`endif

/* include/lpw_pkg.sv */
/*
 * Types of the low-power wake-up gating block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lpw_pkg;
	// Power mode, Gray coded along run-sleep-deep-sleep-power-down-DPD.
	typedef enum logic [2:0] {
		LPW_RUN = 3'h0,
		LPW_SLEEP = 3'h1,
		LPW_DSLEEP = 3'h3,
		LPW_PDOWN = 3'h2,
		LPW_DPD = 3'h6
	} lpw_mode_type;

	// Wake sources as seen from the peripherals and pins.
	typedef struct packed {
		logic gen_irq;        // Any other core interrupt line.
		logic [7:0] pin_irq;  // Pin interrupt lines.
		logic bod_irq;        // Brown-out interrupt.
		logic bod_rst;        // Brown-out reset.
		logic wdt_irq;        // Watchdog interrupt.
		logic wdt_rst;        // Watchdog reset.
		logic wdt_feed;       // Watchdog feed pulse.
		logic [2:0] ser_irq;  // Serial peripheral interrupts.
		logic [2:0] ser_slave; // Serial peripheral is in slave mode.
		logic [2:0] ser_clk;  // External master supplies clock.
		logic touch_irq;      // Touch event interrupt.
		logic touch_wdo;      // Touch function clock is watchdog osc.
		logic reset_pin_n;    // Reset pin line, active low.
		logic wakeup_pin_n;   // Wake-up pin line, active low.
	} lpw_src_type;
endpackage

/* design/lpw_wake_gate.sv */
/*
 * Wake-up qualification for sleep, deep-sleep, power-down and deep
 * power-down, with an AXI4-Lite register slave and a level interrupt.
 * Assumes sources are synchronous to clk and the bus master keeps at
 * most one write and one read outstanding.
 */
`timescale 1ns/100ps
`include "lpw_defines.svh"

module lpw_wake_gate
	import lpw_pkg::*;
(
	input wire logic clk, // 100 MHz system clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire lpw_src_type src, // Wake sources.
	output logic wake_req, // Registered wake pulse.
	output logic wake_reset, // Wake was a reset-type source.
	output logic [2:0] power_mode, // Current power mode.
	output logic dpd_power_off, // Domains other than pin/timer off.
	output logic irq // Level interrupt.
);
	// ============================================================
	// Bus slave state.
	logic aw_held, w_held, next_aw_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic do_write, do_read, wr_ok, rd_ok;
	logic [31:0] rd_val;

	// ============================================================
	// Configuration and status registers.
	lpw_mode_type mode, next_mode;
	logic pin_function_enable_reg, next_pinfn;
	logic [7:0] start_logic_enable_pins, next_stpins;
	logic [4:0] start_logic_enable_periph, next_stper;
	logic [1:0] brownout_control, next_bodctl;
	logic [1:0] sleep_power_config, next_slppwr;
	logic [2:0] watchdog_mode_reg, next_wdmode;
	logic [3:0] deep_powerdown_control, next_dpdctl;
	logic wkt_clk_sel, next_wkt_sel;
	logic [31:0] wkt_count, next_wkt_count;
	logic wkt_flag, next_wkt_flag;
	logic [15:0] core_en, next_core_en;
	logic [1:0] status, next_status, mask, next_mask;
	logic [12:0] wake_src, next_wake_src;
	logic wdt_running, next_wdt_running;
	logic [15:0] div_cnt, next_div_cnt;
	logic wake_q, next_wake_q, wrst_q, next_wrst_q;

	// ============================================================
	// Wake qualification.
	logic in_sleep, in_deep, in_dpd, bod_pwr, wdo_pwr, lp_tick;
	logic [12:0] qual;
	logic wake_any, wake_rst_any, wkt_run, wkt_expire;

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = !rvalid;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	// Mode decode and power conditions kept in the sleep configuration.
	always_comb begin
		in_sleep = (mode == LPW_SLEEP);
		in_deep = (mode == LPW_DSLEEP) || (mode == LPW_PDOWN);
		in_dpd = (mode == LPW_DPD);
		bod_pwr = sleep_power_config[`LPW_SLP_BODPWR];
		wdo_pwr = sleep_power_config[`LPW_SLP_WDOPWR];
	end

	// Each source with all its enables; in DPD only pins and timer count.
	always_comb begin
		qual[0] = in_sleep && src.gen_irq && core_en[`LPW_CORE_GEN];
		qual[1] = in_sleep && |(src.pin_irq & core_en[7:0]);
		qual[2] = (in_sleep || in_deep) && pin_function_enable_reg &&
			!src.reset_pin_n;
		qual[3] = in_deep &&
			|(src.pin_irq & core_en[7:0] & start_logic_enable_pins);
		qual[4] = in_deep && src.bod_irq && core_en[`LPW_CORE_BOD] &&
			start_logic_enable_periph[`LPW_SP_BOD] &&
			brownout_control[`LPW_BOD_IRQEN] && bod_pwr;
		qual[5] = in_deep && src.bod_rst &&
			brownout_control[`LPW_BOD_RSTEN] && bod_pwr;
		qual[6] = in_deep && src.wdt_irq && wdt_running &&
			watchdog_mode_reg[`LPW_WD_IRQEN] && wdo_pwr &&
			core_en[`LPW_CORE_WDT] &&
			start_logic_enable_periph[`LPW_SP_WDT];
		qual[7] = in_deep && src.wdt_rst && wdt_running &&
			watchdog_mode_reg[`LPW_WD_RSTEN] && wdo_pwr;
		qual[8] = in_deep && wkt_flag && core_en[`LPW_CORE_WKT] &&
			start_logic_enable_periph[`LPW_SP_WKT];
		qual[9] = in_deep && start_logic_enable_periph[`LPW_SP_SER] &&
			|(src.ser_irq & src.ser_slave & src.ser_clk &
			core_en[`LPW_CORE_SER_LO+2:`LPW_CORE_SER_LO]);
		qual[10] = in_deep && src.touch_irq && src.touch_wdo && wdo_pwr &&
			core_en[`LPW_CORE_TOUCH] &&
			start_logic_enable_periph[`LPW_SP_TOUCH];
		qual[11] = in_dpd && deep_powerdown_control[`LPW_DPD_WKPIN] &&
			!src.wakeup_pin_n;
		qual[12] = in_dpd && (deep_powerdown_control[`LPW_DPD_RSTPIN] &&
			!src.reset_pin_n || wkt_flag &&
			deep_powerdown_control[`LPW_DPD_LPOSC] &&
			deep_powerdown_control[`LPW_DPD_LPKEEP] &&
			wkt_clk_sel);
		wake_any = |qual;
		wake_rst_any = qual[2] || qual[5] || qual[7] || qual[12];
	end

	// The timer only ticks while its low-power clock would really run.
	always_comb begin
		wkt_run = deep_powerdown_control[`LPW_DPD_LPOSC] && wkt_clk_sel &&
			(!in_dpd || deep_powerdown_control[`LPW_DPD_LPKEEP]);
		lp_tick = wkt_run && (div_cnt == 16'h0000);
		wkt_expire = lp_tick && (wkt_count == 32'h0000_0001);
	end

	// Bus handshake decode; address and data may arrive in either order.
	always_comb begin
		do_write = (aw_held || s_axi_awvalid) &&
			(w_held || s_axi_wvalid) && !bvalid;
		do_read = s_axi_arvalid && !rvalid;
		next_aw_addr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr
			: aw_addr;
		next_w_data = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data;
		wr_ok = (next_aw_addr <= `LPW_OFS_MASK) &&
			(next_aw_addr[1:0] == 2'h0);
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`LPW_OFS_MODE: rd_val = {29'h0, mode};
			`LPW_OFS_PINFN: rd_val = {31'h0, pin_function_enable_reg};
			`LPW_OFS_STPINS: rd_val = {24'h0, start_logic_enable_pins};
			`LPW_OFS_STPER: rd_val = {27'h0, start_logic_enable_periph};
			`LPW_OFS_BODCTL: rd_val = {30'h0, brownout_control};
			`LPW_OFS_SLPPWR: rd_val = {30'h0, sleep_power_config};
			`LPW_OFS_WDMODE: rd_val = {29'h0, watchdog_mode_reg};
			`LPW_OFS_DPDCTL: rd_val = {28'h0, deep_powerdown_control};
			`LPW_OFS_WKTCTL: rd_val = {31'h0, wkt_clk_sel};
			`LPW_OFS_WKTCNT: rd_val = wkt_count;
			`LPW_OFS_COREEN: rd_val = {16'h0, core_en};
			`LPW_OFS_STATUS: rd_val = {30'h0, status};
			`LPW_OFS_MASK: rd_val = {30'h0, mask};
			`LPW_OFS_WSRC: rd_val = {19'h0, wake_src};
			default: begin
				rd_val = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	// Next values of bus and register state.
	always_comb begin
		next_aw_held = do_write ? 1'b0 : (aw_held || s_axi_awvalid);
		next_w_held = do_write ? 1'b0 : (w_held || s_axi_wvalid);
		next_bvalid = do_write || (bvalid && !s_axi_bready);
		next_bresp = do_write ? (wr_ok ? 2'h0 : 2'h2) : bresp;
		next_rvalid = do_read || (rvalid && !s_axi_rready);
		next_rdata = do_read ? rd_val : rdata;
		next_rresp = do_read ? (rd_ok ? 2'h0 : 2'h2) : rresp;
		next_mode = mode;
		next_pinfn = pin_function_enable_reg;
		next_stpins = start_logic_enable_pins;
		next_stper = start_logic_enable_periph;
		next_bodctl = brownout_control;
		next_slppwr = sleep_power_config;
		next_wdmode = watchdog_mode_reg;
		next_dpdctl = deep_powerdown_control;
		next_wkt_sel = wkt_clk_sel;
		next_core_en = core_en;
		next_mask = mask;
		next_wkt_count = wkt_count;
		next_wkt_flag = wkt_flag;
		next_div_cnt = (div_cnt == 16'h0000) ? `LPW_LPOSC_DIV
			: div_cnt - 16'h0001;
		if (do_write && wr_ok && (s_axi_wstrb[0])) begin
			case (next_aw_addr)
				`LPW_OFS_MODE: begin
					if (lpw_mode_type'(next_w_data[2:0]) inside {LPW_RUN,
						LPW_SLEEP, LPW_DSLEEP, LPW_PDOWN, LPW_DPD}) begin
						next_mode = lpw_mode_type'(next_w_data[2:0]);
					end
				end
				`LPW_OFS_PINFN: next_pinfn = next_w_data[0];
				`LPW_OFS_STPINS: next_stpins = next_w_data[7:0];
				`LPW_OFS_STPER: next_stper = next_w_data[4:0];
				`LPW_OFS_BODCTL: next_bodctl = next_w_data[1:0];
				`LPW_OFS_SLPPWR: next_slppwr = next_w_data[1:0];
				`LPW_OFS_WDMODE: next_wdmode = next_w_data[2:0];
				`LPW_OFS_DPDCTL: next_dpdctl = next_w_data[3:0];
				`LPW_OFS_WKTCTL: next_wkt_sel = next_w_data[0];
				`LPW_OFS_COREEN: next_core_en = next_w_data[15:0];
				`LPW_OFS_MASK: next_mask = next_w_data[1:0];
				default: next_mode = mode;
			endcase
		end
		// Writing the count restarts the countdown and drops an old expiry.
		if (do_write && wr_ok && next_aw_addr == `LPW_OFS_WKTCNT) begin
			next_wkt_count = next_w_data;
			next_wkt_flag = 1'b0;
		end else if (lp_tick && wkt_count != 32'h0) begin
			next_wkt_count = wkt_count - 32'h0000_0001;
		end
		if (wkt_expire) begin
			next_wkt_flag = 1'b1;
		end
		// A qualified wake returns the block to run, winning over a write.
		if (wake_any) begin
			next_mode = LPW_RUN;
		end
	end

	// Sticky status: a read clears it, but a same-cycle event still sets.
	always_comb begin
		next_status = status;
		if (do_read && s_axi_araddr == `LPW_OFS_STATUS) begin
			next_status = 2'h0;
		end
		next_status[`LPW_ST_WAKE] = next_status[`LPW_ST_WAKE] || wake_any;
		next_status[`LPW_ST_WKT] = next_status[`LPW_ST_WKT] || wkt_expire;
		next_wake_src = wake_any ? qual : wake_src;
		next_wake_q = wake_any;
		next_wrst_q = wake_rst_any;
		// The watchdog cannot be stopped once fed while enabled.
		next_wdt_running = wdt_running ||
			(src.wdt_feed && watchdog_mode_reg[`LPW_WD_EN]);
	end

	// Register stage for everything above.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= `LPW_RST_ZERO;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= `LPW_RST_ZERO;
			mode <= LPW_RUN;
			pin_function_enable_reg <= 1'b0;
			start_logic_enable_pins <= 8'h00;
			start_logic_enable_periph <= 5'h00;
			brownout_control <= 2'h0;
			sleep_power_config <= 2'h0;
			watchdog_mode_reg <= 3'h0;
			deep_powerdown_control <= 4'h0;
			wkt_clk_sel <= 1'b0;
			wkt_count <= `LPW_RST_ZERO;
			wkt_flag <= 1'b0;
			core_en <= 16'h0000;
			status <= 2'h0;
			mask <= 2'h0;
			wake_src <= 13'h0000;
			wdt_running <= 1'b0;
			div_cnt <= 16'h0000;
			wake_q <= 1'b0;
			wrst_q <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			mode <= next_mode;
			pin_function_enable_reg <= next_pinfn;
			start_logic_enable_pins <= next_stpins;
			start_logic_enable_periph <= next_stper;
			brownout_control <= next_bodctl;
			sleep_power_config <= next_slppwr;
			watchdog_mode_reg <= next_wdmode;
			deep_powerdown_control <= next_dpdctl;
			wkt_clk_sel <= next_wkt_sel;
			wkt_count <= next_wkt_count;
			wkt_flag <= next_wkt_flag;
			core_en <= next_core_en;
			status <= next_status;
			mask <= next_mask;
			wake_src <= next_wake_src;
			wdt_running <= next_wdt_running;
			div_cnt <= next_div_cnt;
			wake_q <= next_wake_q;
			wrst_q <= next_wrst_q;
		end
	end

	assign wake_req = wake_q;
	assign wake_reset = wrst_q;
	assign power_mode = mode;
	assign dpd_power_off = in_dpd;
	assign irq = |(status & mask);

	// ============================================================
	// Checks.
	a_sleep_irq: assert property (@(posedge clk) disable iff (!rst_n)
		in_sleep && src.gen_irq && core_en[`LPW_CORE_GEN] |=> wake_req)
		else $error("enabled interrupt did not wake sleep");
	a_reset_pin: assert property (@(posedge clk) disable iff (!rst_n)
		(in_sleep || in_deep) && !pin_function_enable_reg && !wake_any
		|=> !wake_req)
		else $error("reset pin woke without its function enabled");
	a_pin_start: assert property (@(posedge clk) disable iff (!rst_n)
		qual[3] |-> |(start_logic_enable_pins & src.pin_irq))
		else $error("pin wake without start-logic enable");
	a_bod_power: assert property (@(posedge clk) disable iff (!rst_n)
		(qual[4] || qual[5]) |-> bod_pwr && in_deep)
		else $error("brown-out wake with detector unpowered");
	a_wdt_running: assert property (@(posedge clk) disable iff (!rst_n)
		(qual[6] || qual[7]) |-> wdt_running && wdo_pwr)
		else $error("watchdog wake while not running");
	a_wkt_expiry: assert property (@(posedge clk) disable iff (!rst_n)
		wkt_expire && !(do_write && next_aw_addr == `LPW_OFS_WKTCNT)
		|=> wkt_flag && wkt_count == 32'h0)
		else $error("timer expiry not flagged");
	a_dpd_only: assert property (@(posedge clk) disable iff (!rst_n)
		in_dpd |-> qual[10:0] == 11'h0)
		else $error("powered-off source woke deep power-down");
	a_wake_exit: assert property (@(posedge clk) disable iff (!rst_n)
		wake_any |=> wake_req && mode == LPW_RUN && status[`LPW_ST_WAKE])
		else $error("wake did not return to run");
	a_wake_or: assert property (@(posedge clk) disable iff (!rst_n)
		wake_req == $past(|qual))
		else $error("wake request not the OR of sources");
	c_dpd_pin: cover property (@(posedge clk) disable iff (!rst_n)
		in_dpd ##1 qual[11]);
	c_deep_wdt: cover property (@(posedge clk) disable iff (!rst_n)
		qual[6]);
	c_sleep_wake: cover property (@(posedge clk) disable iff (!rst_n)
		in_sleep ##1 wake_req);
endmodule // lpw_wake_gate

/* sim/tb.sv */
/*
 * Self-checking bench for the wake-up gating block: register access over
 * AXI4-Lite, then wake attempts from every low-power mode with and without
 * one enable that each source needs.
 * Assumes lpw_pkg is compiled first and lpw_defines.svh is on the path.
 */
`timescale 1ns/100ps
`include "lpw_defines.svh"

module tb
	import lpw_pkg::*;
;
	logic clk, rst_n;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	lpw_src_type src;
	logic wake_req, wake_reset, dpd_power_off, irq;
	logic [2:0] power_mode;
	int errors, n_tests;

	lpw_wake_gate lpw_wake_gate_inst (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .src(src), .wake_req(wake_req),
		.wake_reset(wake_reset), .power_mode(power_mode),
		.dpd_power_off(dpd_power_off), .irq(irq)
	);

	// ============================================================
	// Clock, verdict and watchdog.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// The full run needs well under a tenth of this span.
	initial begin
		#200000;
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		print_verdict();
	end

	// ============================================================
	// Helpers.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: %s", $time, m);
		end
	endtask

	// Sources at rest: the two pin lines are active low, so they idle high.
	function automatic lpw_src_type idle();
		lpw_src_type s;
		s = '0;
		s.reset_pin_n = 1'b1;
		s.wakeup_pin_n = 1'b1;
		return s;
	endfunction

	// Address and data are offered together; bready stays high throughout.
	// Ready is sampled mid-cycle, so the edge that takes an item is known
	// before it comes; reading it just after that edge would race.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		int n;
		logic aw_p, w_p;
		n = 0;
		aw_p = 1'b1;
		w_p = 1'b1;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		while ((aw_p || w_p) && n < 50) begin
			@(negedge clk);
			n++;
			if (aw_p && s_axi_awready) aw_p = 1'b0;
			if (w_p && s_axi_wready) w_p = 1'b0;
			@(posedge clk);
			if (!aw_p) s_axi_awvalid <= 1'b0;
			if (!w_p) s_axi_wvalid <= 1'b0;
		end
		do begin
			@(negedge clk);
			n++;
		end while (!s_axi_bvalid && n < 50);
		chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write response");
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = 2'h0);
		int n;
		logic ar_p;
		n = 0;
		ar_p = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (ar_p && n < 50) begin
			@(negedge clk);
			n++;
			if (s_axi_arready) ar_p = 1'b0;
			@(posedge clk);
			if (!ar_p) s_axi_arvalid <= 1'b0;
		end
		do begin
			@(negedge clk);
			n++;
		end while (!s_axi_rvalid && n < 50);
		chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er}, "read response");
		chk(s_axi_rdata, ed, "read data");
		@(posedge clk);
	endtask

	// The count register is skipped: rewriting it would restart the timer.
	task automatic clr();
		for (int a = 4; a <= 40; a += 4) begin
			if (a != 36) wr(a[7:0], 32'h0);
		end
	endtask

	// Enter a mode, present sources, and see whether and how it ends.
	task automatic tw(input lpw_src_type s, input lpw_mode_type m,
		input logic ew, input logic er);
		int n;
		wr(`LPW_OFS_MODE, {29'h0, m});
		chk(power_mode, m, "mode entry");
		chk(dpd_power_off, m == LPW_DPD, "power domains");
		src <= s;
		n = 0;
		// The wake pulse lasts one cycle, so it is looked at mid-cycle.
		do begin
			@(negedge clk);
			n++;
		end while (wake_req !== 1'b1 && n < 60);
		chk(wake_req, ew, "wake request");
		if (ew) begin
			chk(wake_reset, er, "wake kind");
			chk(power_mode, LPW_RUN, "mode after wake");
		end
		@(posedge clk);
		src <= idle();
		if (!ew) wr(`LPW_OFS_MODE, 32'h0);
	endtask

	// ============================================================
	// Main sequence.
	initial begin
		lpw_src_type s;
		errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		src = idle();
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset values and refused accesses.
		rd(`LPW_OFS_MODE, 32'h0);
		rd(`LPW_OFS_COREEN, 32'h0);
		rd(8'h38, 32'h0, 2'h2);
		wr(`LPW_OFS_WSRC, 32'h1, 2'h2);
		wr(8'h02, 32'h1, 2'h2);
		chk(irq, 1'b0, "irq after reset");
		// Sleep ends on the enabled general interrupt line, then irq via status.
		wr(`LPW_OFS_COREEN, 32'h8000);
		s = idle();
		s.gen_irq = 1'b1;
		tw(s, LPW_SLEEP, 1'b1, 1'b0); // Enabled line wakes.
		wr(`LPW_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1, "irq raised");
		rd(`LPW_OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0, "irq cleared by read");
		clr();
		tw(s, LPW_SLEEP, 1'b0, 1'b0); // Disabled line is ignored.
		// Reset pin in the three shallow modes.
		wr(`LPW_OFS_PINFN, 32'h1);
		s = idle();
		s.reset_pin_n = 1'b0;
		tw(s, LPW_SLEEP, 1'b1, 1'b1); // Pin function on.
		tw(s, LPW_DSLEEP, 1'b1, 1'b1); // Pin function on.
		tw(s, LPW_PDOWN, 1'b1, 1'b1); // Pin function on.
		clr();
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Pin function off.
		// Pin interrupts need both enables; lowest and highest line.
		wr(`LPW_OFS_COREEN, 32'h81);
		wr(`LPW_OFS_STPINS, 32'h80);
		s = idle();
		s.pin_irq = 8'h80;
		tw(s, LPW_PDOWN, 1'b1, 1'b0); // Both enables set.
		s.pin_irq = 8'h01;
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Start-logic bit off.
		// Brown-out interrupt and reset.
		clr();
		wr(`LPW_OFS_COREEN, 32'h100);
		wr(`LPW_OFS_STPER, 32'h1);
		wr(`LPW_OFS_BODCTL, 32'h1);
		wr(`LPW_OFS_SLPPWR, 32'h1);
		s = idle();
		s.bod_irq = 1'b1;
		tw(s, LPW_DSLEEP, 1'b1, 1'b0); // All conditions met.
		wr(`LPW_OFS_SLPPWR, 32'h0);
		tw(s, LPW_PDOWN, 1'b0, 1'b0); // Detector unpowered.
		wr(`LPW_OFS_SLPPWR, 32'h1);
		wr(`LPW_OFS_BODCTL, 32'h2);
		s = idle();
		s.bod_rst = 1'b1;
		tw(s, LPW_PDOWN, 1'b1, 1'b1); // Reset enabled.
		wr(`LPW_OFS_BODCTL, 32'h1);
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Reset enable off.
		// Watchdog: idle until fed, then interrupt and reset.
		clr();
		wr(`LPW_OFS_WDMODE, 32'h5);
		wr(`LPW_OFS_SLPPWR, 32'h2);
		wr(`LPW_OFS_COREEN, 32'h200);
		wr(`LPW_OFS_STPER, 32'h2);
		s = idle();
		s.wdt_irq = 1'b1;
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Not yet running.
		@(posedge clk);
		src.wdt_feed <= 1'b1;
		@(posedge clk);
		src.wdt_feed <= 1'b0;
		tw(s, LPW_DSLEEP, 1'b1, 1'b0); // Fed and enabled.
		wr(`LPW_OFS_WDMODE, 32'h3);
		s = idle();
		s.wdt_rst = 1'b1;
		tw(s, LPW_PDOWN, 1'b1, 1'b1); // Running, reset on.
		wr(`LPW_OFS_SLPPWR, 32'h0);
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Oscillator unpowered.
		// Serial slaves, each channel, then one without a clock.
		clr();
		wr(`LPW_OFS_STPER, 32'h8);
		for (int i = 0; i < 3; i++) begin
			wr(`LPW_OFS_COREEN, 32'h800 << i);
			s = idle();
			s.ser_irq[i] = 1'b1;
			s.ser_slave[i] = 1'b1;
			s.ser_clk[i] = 1'b1;
			tw(s, LPW_DSLEEP, 1'b1, 1'b0); // Slave with clock.
		end
		s.ser_clk = 3'h0;
		tw(s, LPW_PDOWN, 1'b0, 1'b0); // No external clock.
		// Touch sensor.
		clr();
		wr(`LPW_OFS_COREEN, 32'h4000);
		wr(`LPW_OFS_STPER, 32'h10);
		wr(`LPW_OFS_SLPPWR, 32'h2);
		s = idle();
		s.touch_irq = 1'b1;
		s.touch_wdo = 1'b1;
		tw(s, LPW_PDOWN, 1'b1, 1'b0); // Clocked from oscillator.
		s.touch_wdo = 1'b0;
		tw(s, LPW_DSLEEP, 1'b0, 1'b0); // Wrong function clock.
		// Deep power-down: only pins and timer may end it.
		clr();
		wr(`LPW_OFS_COREEN, 32'hffff);
		wr(`LPW_OFS_PINFN, 32'h1);
		s = idle();
		s.gen_irq = 1'b1;
		s.pin_irq = 8'hff;
		tw(s, LPW_DPD, 1'b0, 1'b0); // Interrupts are unpowered.
		s = idle();
		s.reset_pin_n = 1'b0;
		tw(s, LPW_DPD, 1'b0, 1'b0); // Reset pin not enabled.
		wr(`LPW_OFS_DPDCTL, 32'h2);
		tw(s, LPW_DPD, 1'b1, 1'b1); // Reset pin enabled.
		s = idle();
		s.wakeup_pin_n = 1'b0;
		tw(s, LPW_DPD, 1'b0, 1'b0); // Wake pin not enabled.
		wr(`LPW_OFS_DPDCTL, 32'h1);
		tw(s, LPW_DPD, 1'b1, 1'b0); // Wake pin enabled.
		// Timer: ten clocks a tick, so a count of 3 needs 30 clocks.
		clr();
		wr(`LPW_OFS_COREEN, 32'h400);
		wr(`LPW_OFS_STPER, 32'h4);
		wr(`LPW_OFS_DPDCTL, 32'h4);
		wr(`LPW_OFS_WKTCTL, 32'h1);
		wr(`LPW_OFS_WKTCNT, 32'h3);
		tw(idle(), LPW_DSLEEP, 1'b1, 1'b0); // Count expires.
		rd(`LPW_OFS_STATUS, 32'h3); // Wake and expiry flags.
		wr(`LPW_OFS_WKTCNT, 32'h3);
		tw(idle(), LPW_DPD, 1'b0, 1'b0); // Oscillator not kept.
		wr(`LPW_OFS_DPDCTL, 32'hc);
		wr(`LPW_OFS_WKTCNT, 32'h3);
		tw(idle(), LPW_DPD, 1'b1, 1'b1); // Kept running.
		rd(`LPW_OFS_WSRC, 32'h1000); // Source of the last wake.
		print_verdict();
	end
endmodule // tb
